/* design/bilr_regs.sv */
/*
  Configuration register slice: subsystem identifiers with write lock and
  EEPROM load, shared legacy base, and system control per function.
  Assumes cfg and EEPROM load strobes come from logic on ref_clk; the bus
  reset and EEPROM presence arrive from pins.
*/
`include "bilr_map.svh"

module bilr_regs
  import bilr_pkg::*;
(
  // Clock and global reset
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  // Bus reset pin
  input  wire logic          bus_rst_n,
  // Configuration access
  input  bilr_cfg_req_t      cfg_req,
  output logic               cfg_ack,
  output logic [31:0]        cfg_rdata,
  // EEPROM loader
  input  wire logic          ee_present,
  input  wire logic          ee_load,
  input  bilr_id_pair_t      ee_ids,
  output logic               ee_loaded,
  // Legacy I/O window
  input  wire logic          io_valid,
  input  wire logic [31:0]   io_addr,
  output bilr_io_hit_t       io_hit,
  // State seen by the rest of the bridge
  output logic [1:0]         id_write_lock,
  output logic [31:0]        legacy_index_base_address,
  output logic [63:0]        system_control_word
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NF = `BILR_FUNC_COUNT;

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [1:0] bus_rst_sync;
  logic [1:0] ee_present_sync;
  logic       bus_rst_hit;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rst_sync    <= 2'b11;
      ee_present_sync <= 2'b00;
    end else begin
      bus_rst_sync    <= {bus_rst_sync[0], bus_rst_n};
      ee_present_sync <= {ee_present_sync[0], ee_present};
    end
  end

  assign bus_rst_hit = !bus_rst_sync[1];

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  logic [15:0] subsystem_identifier [NF];
  logic [15:0] subsys_vendor        [NF];
  logic [31:0] sys_ctrl             [NF];
  logic [15:0] next_subsys_id       [NF];
  logic [15:0] next_subsys_vendor   [NF];
  logic [31:0] next_sys_ctrl        [NF];
  logic [31:0] next_legacy;
  logic        load_armed;
  logic        next_load_armed;
  logic        next_ee_loaded;
  logic        do_load;
  logic        wr_legacy;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be,
                                        input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~lanes) | (new_v & lanes);
  endfunction

  // -----------------------------------------------------------------
  // Dword index decode
  // -----------------------------------------------------------------
  logic hit_ids;
  logic hit_legacy;
  logic hit_ctrl;

  assign hit_ids    = (cfg_req.addr == 6'(`BILR_OFF_SUBSYS_VENDOR >> 2));
  assign hit_legacy = (cfg_req.addr == 6'(`BILR_OFF_LEGACY_BASE >> 2));
  assign hit_ctrl   = (cfg_req.addr == 6'(`BILR_OFF_SYS_CTRL >> 2));
  assign wr_legacy  = cfg_req.wr && hit_legacy;

  // -----------------------------------------------------------------
  // EEPROM load: accepted once per global reset, only when present
  // -----------------------------------------------------------------
  assign do_load = ee_load && load_armed && ee_present_sync[1];

  always_comb begin
    next_load_armed = load_armed && !do_load;
    next_ee_loaded  = ee_loaded || do_load;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      load_armed <= 1'b1;
      ee_loaded  <= 1'b0;
    end else begin
      load_armed <= next_load_armed;
      ee_loaded  <= next_ee_loaded;
    end
  end

  // -----------------------------------------------------------------
  // Shared legacy base: one register behind both functions
  // -----------------------------------------------------------------
  always_comb begin
    next_legacy     = legacy_index_base_address;
    if (wr_legacy) begin
      next_legacy = merge(legacy_index_base_address, cfg_req.wdata, cfg_req.be,
                          `BILR_LEGACY_WMASK);
    end
  end

  // -----------------------------------------------------------------
  // Per-function identifier and system control
  // -----------------------------------------------------------------
  for (genvar f = 0; f < NF; f++) begin : g_func
    logic        sel;
    logic [31:0] id_word;
    logic [31:0] id_merged;

    assign sel     = cfg_req.wr && (cfg_req.func == 1'(f));
    assign id_word = {subsystem_identifier[f], subsys_vendor[f]};

    always_comb begin
      id_merged             = merge(id_word, cfg_req.wdata, cfg_req.be, 32'hFFFF_FFFF);
      next_subsys_id[f]     = subsystem_identifier[f];
      next_subsys_vendor[f] = subsys_vendor[f];
      next_sys_ctrl[f]      = sys_ctrl[f];
      if (do_load) begin
        next_subsys_id[f]     = ee_ids.subsys_id;
        next_subsys_vendor[f] = ee_ids.vendor_id;
      end else if (sel && hit_ids
                   && !sys_ctrl[f][`BILR_ID_WRITE_LOCK_BIT]) begin
        next_subsys_id[f]     = id_merged[31:16];
        next_subsys_vendor[f] = id_merged[15:0];
      end
      if (sel && hit_ctrl) begin
        next_sys_ctrl[f] = merge(sys_ctrl[f], cfg_req.wdata, cfg_req.be,
                                 `BILR_SYS_CTRL_WMASK);
      end
      if (bus_rst_hit) begin
        next_sys_ctrl[f] = next_sys_ctrl[f] & ~`BILR_SYS_CTRL_BUSRST;
      end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        subsystem_identifier[f] <= `BILR_ID_RESET;
        subsys_vendor[f]        <= `BILR_ID_RESET;
        sys_ctrl[f]             <= `BILR_SYS_CTRL_RESET;
      end else begin
        subsystem_identifier[f] <= next_subsys_id[f];
        subsys_vendor[f]        <= next_subsys_vendor[f];
        sys_ctrl[f]             <= next_sys_ctrl[f];
      end
    end

    assign id_write_lock[f]                 = sys_ctrl[f][`BILR_ID_WRITE_LOCK_BIT];
    assign system_control_word[32*f +: 32]  = sys_ctrl[f];
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      legacy_index_base_address <= `BILR_LEGACY_RESET;
    end else begin
      legacy_index_base_address <= next_legacy;
    end
  end

  // -----------------------------------------------------------------
  // Read path: one cycle after the strobe
  // -----------------------------------------------------------------
  logic [31:0] next_rdata;
  logic        next_ack;

  always_comb begin
    next_ack   = cfg_req.rd || cfg_req.wr;
    next_rdata = 32'h0000_0000;
    if (cfg_req.rd) begin
      case (cfg_req.addr)
        6'(`BILR_OFF_SUBSYS_VENDOR >> 2):
          next_rdata = {subsystem_identifier[cfg_req.func], subsys_vendor[cfg_req.func]};
        6'(`BILR_OFF_LEGACY_BASE >> 2):
          next_rdata = legacy_index_base_address | 32'h0000_0001;
        6'(`BILR_OFF_SYS_CTRL >> 2):
          next_rdata = sys_ctrl[cfg_req.func];
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack   <= next_ack;
      cfg_rdata <= next_rdata;
    end
  end

  // -----------------------------------------------------------------
  // Legacy window decode
  // -----------------------------------------------------------------
  bilr_io_decode u_io_decode (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .base     (legacy_index_base_address),
    .io_valid (io_valid),
    .io_addr  (io_addr),
    .io_hit   (io_hit)
  );
endmodule // bilr_regs

/* design/bilr_map.svh */
/*
  Offsets, field positions, reset values and masks of the bridge
  identifier and legacy index register slice.
  Assumes it is included by bare name from the package and the modules.
*/
// What this block does
// - The subsystem identifier is writable while the id_write_lock bit (system control bit 5) is 0 and read-only while it is 1.
// - After reset the identifier registers are read-only because id_write_lock resets to 1.
// - With an EEPROM attached, both subsystem identifier and vendor identifier are loaded from it once after each global reset.
// - The marked bits of the identifier, legacy base and system control registers clear only on global reset, not on bus reset.
// - The I/O address in the legacy base register selects the legacy_socket_regs index register, and that address plus one its data register.
// - Bit 0 of the legacy base register ignores writes and reads as 1; all other bits are writable.
// - The legacy base register is one shared register, so a write through function 0 or 1 is seen by both.
// - The subsystem vendor identifier at offset 40h follows the same write lock as the subsystem identifier.
`ifndef BILR_MAP_SVH
`define BILR_MAP_SVH

// -----------------------------------------------------------------
// Byte offsets in each function's configuration space
// -----------------------------------------------------------------
`define BILR_OFF_SUBSYS_VENDOR  8'h40
`define BILR_OFF_SUBSYS_ID      8'h42
`define BILR_OFF_LEGACY_BASE    8'h44
`define BILR_OFF_SYS_CTRL       8'h80

// -----------------------------------------------------------------
// Fields, reset values and masks
// -----------------------------------------------------------------
`define BILR_ID_WRITE_LOCK_BIT  5
`define BILR_ID_RESET           16'h0000
`define BILR_LEGACY_RESET       32'h0000_0001
`define BILR_LEGACY_WMASK       32'hFFFF_FFFE
`define BILR_SYS_CTRL_RESET     32'h0000_0020
`define BILR_SYS_CTRL_WMASK     32'hFF7F_C07B
`define BILR_SYS_CTRL_BUSRST    32'h1000_0000
`define BILR_FUNC_COUNT         2

`endif

/* design/bilr_pkg.sv */
/*
  Types shared by the bridge identifier and legacy index register slice.
  Assumes bilr_map.svh is on the include path.
*/
package bilr_pkg;
  `include "bilr_map.svh"

  // -----------------------------------------------------------------
  // Configuration access request
  // -----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        func;
    logic [7:2]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bilr_cfg_req_t;

  // -----------------------------------------------------------------
  // Identifier pair loaded from the EEPROM
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] subsys_id;
    logic [15:0] vendor_id;
  } bilr_id_pair_t;

  // -----------------------------------------------------------------
  // Legacy window decode result
  // -----------------------------------------------------------------
  typedef struct packed {
    logic index_hit;
    logic data_hit;
  } bilr_io_hit_t;
endpackage

/* design/bilr_io_decode.sv */
/*
  Decoder for the legacy index/data I/O window placed by the legacy base.
  Assumes io_addr and io_valid come from logic on ref_clk.
*/
module bilr_io_decode
  import bilr_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Window base and access
  input  wire logic [31:0]  base,
  input  wire logic         io_valid,
  input  wire logic [31:0]  io_addr,
  // Result
  output bilr_io_hit_t      io_hit
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0]  index_addr;
  logic [31:0]  data_addr;
  bilr_io_hit_t next_io_hit;

  always_comb begin
    index_addr            = {base[31:1], 1'b0};
    data_addr             = index_addr + 32'h0000_0001;
    next_io_hit.index_hit = io_valid && (io_addr == index_addr);
    next_io_hit.data_hit  = io_valid && (io_addr == data_addr);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      io_hit <= '0;
    end else begin
      io_hit <= next_io_hit;
    end
  end
endmodule // bilr_io_decode

/* test/bilr_regs_asserts.sv */
/*
  Checker for the port behaviour of bilr_regs.
  Assumes it is bound into bilr_regs; one clock, ref_clk.
*/
module bilr_regs_chk
  import bilr_pkg::*;
(
  // Clock and resets
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        bus_rst_n,
  // Register port
  input bilr_cfg_req_t    cfg_req,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  // Loader and window
  input wire logic        ee_load,
  input wire logic        ee_loaded,
  input wire logic        io_valid,
  input wire logic [31:0] io_addr,
  input bilr_io_hit_t     io_hit,
  // State
  input wire logic [1:0]  id_write_lock,
  input wire logic [31:0] legacy_index_base_address,
  input wire logic [63:0] system_control_word
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic [30:0] base_hi = legacy_index_base_address[31:1];

  AST_RESET_STATE: assert property ($rose(rstn) |-> id_write_lock == 2'b11
    && legacy_index_base_address == 32'h0000_0001
    && system_control_word == {2{32'h0000_0020}}) else $error("reset state wrong");
  AST_LOCK_WRITE: assert property (cfg_req.wr && cfg_req.addr == 6'h20 && cfg_req.be[0]
    |=> id_write_lock[$past(cfg_req.func)] == $past(cfg_req.wdata[5]))
    else $error("write lock not updated");
  AST_BASE_READ: assert property (cfg_ack && $past(cfg_req.rd && cfg_req.addr == 6'h11)
    |-> cfg_rdata[0]) else $error("legacy base bit 0 read as 0");
  AST_INDEX_HIT: assert property (io_valid && io_addr == {base_hi, 1'b0}
    |=> io_hit == 2'b10) else $error("index address missed");
  AST_DATA_HIT: assert property (io_valid && io_addr == {base_hi, 1'b1}
    |=> io_hit == 2'b01) else $error("data address missed");
  AST_MISS: assert property (io_valid && io_addr[31:1] != base_hi
    |=> io_hit == 2'b00) else $error("window hit outside base");
  AST_LOAD_CAUSE: assert property ($rose(ee_loaded) |-> $past(ee_load))
    else $error("loaded flag without load");
  AST_LOAD_HOLD: assert property (ee_loaded |=> ee_loaded)
    else $error("loaded flag dropped");
  AST_BUS_RESET: assert property (!bus_rst_n && !cfg_req.wr |=> $stable(id_write_lock)
    && $stable(legacy_index_base_address)) else $error("bus reset cleared state");
endmodule // bilr_regs_chk

bind bilr_regs bilr_regs_chk u_chk (.ref_clk, .rstn, .bus_rst_n, .cfg_req, .cfg_ack,
  .cfg_rdata, .ee_load, .ee_loaded, .io_valid, .io_addr, .io_hit, .id_write_lock,
  .legacy_index_base_address, .system_control_word);

/* test/bilr_host.sv */
/*
  Host software model issuing configuration accesses.
  Assumes a one-cycle request pulse answered one cycle later.
*/
module bilr_host
  import bilr_pkg::*;
(
  // Clock
  input wire logic        ref_clk,
  // Register port
  output bilr_cfg_req_t   cfg_req,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cfg_req = '0;
  task automatic access(input logic wr, input logic func, input logic [5:0] addr,
    input logic [3:0] be, input logic [31:0] wdata, output logic ack, output logic [31:0] rdata);
    @(negedge ref_clk);
    // System control writes go through function 0 only
    cfg_req = '{wr: wr, rd: !wr, func: (wr && addr == 6'h20) ? 1'b0 : func,
                addr: addr, be: be, wdata: wdata};
    @(negedge ref_clk);
    ack = cfg_ack;
    rdata = cfg_rdata;
    cfg_req = '0;
  endtask
endmodule // bilr_host

/* test/testbench.sv */
/*
  Self-checking bench for bilr_regs.
  Assumes bilr_host and the bound checker are compiled with it.
*/
module testbench
  import bilr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic wr; logic f; logic [5:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;
  } bilr_row_t;
  logic ref_clk = 0, rstn = 0, bus_rst_n = 1, ee_present = 0, ee_load = 0, io_valid = 0;
  logic [31:0] io_addr = '0, cfg_rdata, rd;
  logic ack, cfg_ack, ee_loaded;
  bilr_id_pair_t ee_ids = '0;
  bilr_cfg_req_t cfg_req;
  bilr_io_hit_t io_hit;
  int failures = 0, checks_done = 0;
  bilr_row_t rows [21] = '{
    '{0,0,6'h10,4'hF,0,0}, '{1,0,6'h10,4'hF,32'hBEEF_1234,0},
    '{0,0,6'h10,4'hF,0,0}, '{0,1,6'h10,4'hF,0,0},
    '{0,0,6'h11,4'hF,0,32'h0000_0001}, '{0,0,6'h20,4'hF,0,32'h0000_0020},
    '{1,0,6'h20,4'hF,0,0}, '{1,0,6'h10,4'hF,32'hBEEF_1234,0},
    '{0,0,6'h10,4'hF,0,32'hBEEF_1234}, '{1,1,6'h10,4'hF,32'h1111_2222,0},
    '{0,1,6'h10,4'hF,0,0}, '{1,0,6'h10,4'hC,32'h5A5A_0000,0},
    '{0,0,6'h10,4'hF,0,32'h5A5A_1234}, '{1,0,6'h11,4'hF,32'h0000_03E0,0},
    '{0,1,6'h11,4'hF,0,32'h0000_03E1}, '{1,1,6'h11,4'hF,32'hFFFF_FFFE,0},
    '{0,0,6'h11,4'hF,0,32'hFFFF_FFFF}, '{0,0,6'h3F,4'hF,0,0},
    '{1,0,6'h20,4'hF,32'h1000_0020,0}, '{1,0,6'h10,4'hF,0,0},
    '{0,0,6'h10,4'hF,0,32'h5A5A_1234}};
  logic [31:0] io_a [3] = '{32'hFFFF_FFFE, 32'hFFFF_FFFF, 32'h7FFF_FFFE};
  logic [1:0] io_e [3] = '{2'b10, 2'b01, 2'b00};

  always #2.5 ref_clk = ~ref_clk;
  bilr_regs DUT (.ref_clk, .rstn, .bus_rst_n, .cfg_req, .cfg_ack, .cfg_rdata, .ee_present,
    .ee_load, .ee_ids, .ee_loaded, .io_valid, .io_addr, .io_hit, .id_write_lock(),
    .legacy_index_base_address(), .system_control_word());
  bilr_host host (.ref_clk, .cfg_req, .cfg_ack, .cfg_rdata);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input bilr_row_t r);
    host.access(r.wr, r.f, r.a, r.be, r.d, ack, rd);
    chk("cfg_ack", 1, ack);
    if (!r.wr) chk("cfg_rdata", r.e, rd);
  endtask
  task automatic ee_pulse(input logic [31:0] ids);
    ee_ids = ids;
    ee_load = 1;
    @(negedge ref_clk);
    ee_load = 0;
  endtask
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge ref_clk);
    rstn = 1;
    foreach (rows[i]) xfer(rows[i]);
    for (int i = 0; i < 3; i++) begin
      @(negedge ref_clk);
      io_valid = 1;
      io_addr = io_a[i];
      @(negedge ref_clk);
      io_valid = 0;
      chk("io_hit", io_e[i], io_hit);
    end
    xfer('{0,0,6'h20,4'hF,0,32'h1000_0020});
    bus_rst_n = 0;
    repeat (4) @(negedge ref_clk);
    bus_rst_n = 1;
    xfer('{0,0,6'h11,4'hF,0,32'hFFFF_FFFF});
    xfer('{0,0,6'h20,4'hF,0,32'h0000_0020});
    ee_present = 1;
    repeat (3) @(negedge ref_clk);
    ee_pulse(32'hC0DE_7777);
    chk("ee_loaded", 1, ee_loaded);
    xfer('{0,1,6'h10,4'hF,0,32'hC0DE_7777});
    ee_pulse(32'h1357_9BDF);
    xfer('{0,0,6'h10,4'hF,0,32'hC0DE_7777});
    rstn = 0;
    ee_present = 0;
    repeat (2) @(negedge ref_clk);
    rstn = 1;
    chk("ee_loaded", 0, ee_loaded);
    repeat (2) @(negedge ref_clk);
    ee_pulse(32'h2468_ACE0);
    chk("ee_loaded", 0, ee_loaded);
    xfer('{0,0,6'h10,4'hF,0,0});
    ee_present = 1;
    repeat (3) @(negedge ref_clk);
    ee_pulse(32'h2468_ACE0);
    xfer('{0,1,6'h10,4'hF,0,32'h2468_ACE0});
    xfer('{0,0,6'h11,4'hF,0,32'h0000_0001});
    stop_test();
  end
  initial begin
    #5000;
    failures++;
    stop_test();
  end
endmodule // testbench
